// [adc_lowpower_config_ctrl_tb_top.sv]
/*
  Testbench: AXI4-Lite register tasks, conversion and stop scenarios.
  Assumes result high holds bits 9:8 and result low bits 7:0.
*/
`timescale 1ns/1ps
module adc_lowpower_config_ctrl_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, light_stop_mode = 0, deep_stop_mode = 0;
  logic hw_trigger = 0;
  logic [7:0] awaddr = 0, araddr = 0, dly = 8'h14;
  logic [31:0] wdata = 0, rdata, v;
  logic [9:0] sample = 10'h2a5, afe_data;
  logic awready, wready, bvalid, arready, rvalid, afe_done, afe_start;
  logic afe_abort, active, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] chan;
  logic [7:0] cfg;
  logic [15:0] pins;
  int error_cnt = 0;
  int cmp_count = 0;
  always #4 aclk = ~aclk;
  adcl_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .light_stop_mode(light_stop_mode), .deep_stop_mode(deep_stop_mode),
    .hw_trigger(hw_trigger), .afe_done(afe_done), .afe_data(afe_data),
    .afe_start(afe_start), .afe_abort(afe_abort), .channel_select(chan),
    .converter_config(cfg), .conv_active_flag(active), .conv_irq(irq),
    .pin_disable(pins));
  adcl_afe_model i_afe (.aclk(aclk), .aresetn(aresetn),
    .afe_start(afe_start), .afe_abort(afe_abort), .delay(dly),
    .sample(sample), .afe_done(afe_done), .afe_data(afe_data));
  task wrap_up;
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("register %h", a), {24'h000000, e}, v);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (active !== 1'b0 && n < 200);
    tick(2);
    if (n >= 200) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  initial begin
    tick(8);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++) rc(8'(4 * i), 8'h00);
    wr(8'h24, 8'h5a);
    chk("write response", 32'(adcl_pkg::RESP_SLVERR), 32'(rsp));
    rc(8'h24, 8'h00);
    chk("read response", 32'(adcl_pkg::RESP_SLVERR), 32'(rsp));
    wr(adcl_pkg::OFS_CONFIG, 8'h98);
    chk("write response ok", 32'(adcl_pkg::RESP_OKAY), 32'(rsp));
    wr(adcl_pkg::OFS_CTRL_TWO, 8'h00);
    wr(adcl_pkg::OFS_CTRL_ONE, 8'h41);
    chk("config port", 32'h98, 32'(cfg));
    chk("channel", 32'h01, 32'(chan));
    chk("active", 32'h1, 32'(active));
    idle();
    rc(adcl_pkg::OFS_CONFIG, 8'h98);
    rc(adcl_pkg::OFS_CTRL_ONE, 8'hc1);
    chk("irq", 32'h1, 32'(irq));
    rc(adcl_pkg::OFS_RES_HIGH, 8'h02);
    rc(adcl_pkg::OFS_RES_LOW, 8'ha5);
    tick(30);
    chk("active single", 32'h0, 32'(active));
    rd(adcl_pkg::OFS_RES_HIGH);
    sample <= 10'h13c;
    wr(adcl_pkg::OFS_CTRL_ONE, 8'h01);
    idle();
    rc(adcl_pkg::OFS_RES_LOW, 8'ha5);
    rc(adcl_pkg::OFS_CTRL_ONE, 8'h81);
    chk("irq masked", 32'h0, 32'(irq));
    wr(adcl_pkg::OFS_CTRL_ONE, 8'h01);
    tick(3);
    light_stop_mode <= 1'b1;
    idle();
    rc(adcl_pkg::OFS_CTRL_ONE, 8'h01);
    rc(adcl_pkg::OFS_RES_HIGH, 8'h02);
    rc(adcl_pkg::OFS_RES_LOW, 8'ha5);
    light_stop_mode <= 1'b0;
    tick(40);
    chk("no resume", 32'h0, 32'(active));
    rc(adcl_pkg::OFS_CTRL_TWO, 8'h00);
    wr(adcl_pkg::OFS_CONFIG, 8'h03);
    wr(adcl_pkg::OFS_CTRL_TWO, 8'h40);
    wr(adcl_pkg::OFS_CTRL_ONE, 8'h02);
    hw_trigger <= 1'b1;
    tick(1);
    hw_trigger <= 1'b0;
    tick(3);
    light_stop_mode <= 1'b1;
    idle();
    rc(adcl_pkg::OFS_CTRL_ONE, 8'h82);
    rc(adcl_pkg::OFS_RES_LOW, 8'h4f);
    chk("read response ok", 32'(adcl_pkg::RESP_OKAY), 32'(rsp));
    hw_trigger <= 1'b1;
    tick(1);
    hw_trigger <= 1'b0;
    tick(2);
    chk("active in stop", 32'h1, 32'(active));
    idle();
    light_stop_mode <= 1'b0;
    wr(adcl_pkg::OFS_CTRL_TWO, 8'h3c);
    rc(adcl_pkg::OFS_CTRL_TWO, 8'h30);
    wr(adcl_pkg::OFS_CONFIG, 8'h08);
    wr(adcl_pkg::OFS_CMP_HIGH, 8'h02);
    wr(adcl_pkg::OFS_CMP_LOW, 8'h00);
    wr(adcl_pkg::OFS_CTRL_TWO, 8'h20);
    sample <= 10'h080;
    wr(adcl_pkg::OFS_CTRL_ONE, 8'h01);
    idle();
    rc(adcl_pkg::OFS_CTRL_ONE, 8'h81);
    rc(adcl_pkg::OFS_RES_HIGH, 8'h02);
    rc(adcl_pkg::OFS_RES_LOW, 8'h80);
    sample <= 10'h300;
    wr(adcl_pkg::OFS_CTRL_ONE, 8'h01);
    idle();
    rc(adcl_pkg::OFS_CTRL_ONE, 8'h01);
    wr(adcl_pkg::OFS_PIN_ONE, 8'h02);
    chk("pin disable", 32'h0002, 32'(pins));
    deep_stop_mode <= 1'b1;
    tick(3);
    deep_stop_mode <= 1'b0;
    tick(1);
    chk("pins after deep", 32'h0, 32'(pins));
    chk("config after deep", 32'h0, 32'(cfg));
    rc(adcl_pkg::OFS_CMP_HIGH, 8'h00);
    wr(adcl_pkg::OFS_CONFIG, 8'h98);
    rc(adcl_pkg::OFS_CONFIG, 8'h98);
    wrap_up();
  end
endmodule

// [adcl_afe_model.sv]
/*
  Analog front end model: answers afe_start with afe_done after a set delay.
  Assumes it shares aclk with the control block; abort cancels the run.
*/
`timescale 1ns/1ps
module adcl_afe_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic afe_start,
  input wire logic afe_abort,
  input wire logic [7:0] delay,
  input wire logic [9:0] sample,
  output logic afe_done,
  output logic [9:0] afe_data
);
  int cnt = 0;
  always @(posedge aclk) begin
    afe_done <= 1'b0;
    // Data not valid outside the done pulse
    afe_data <= ~afe_data;
    if (!aresetn) begin
      cnt <= 0;
      afe_data <= 10'h000;
    end else if (afe_abort) begin
      cnt <= 0;
    end else if (afe_start) begin
      cnt <= int'(delay);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        afe_done <= 1'b1;
        afe_data <= sample;
      end
    end
  end
endmodule

// [adcl_ctrl.sv]
/*
  Converter control block: AXI4-Lite register file, conversion
  sequencing, light and deep stop handling, result lock, compare.
  Assumes the analog front end and stop requests run on aclk.
*/
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adcl_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic light_stop_mode,
  input wire logic deep_stop_mode,
  input wire logic hw_trigger,
  input wire logic afe_done,
  input wire logic [9:0] afe_data,
  output logic afe_start,
  output logic afe_abort,
  output logic [4:0] channel_select,
  output logic [7:0] converter_config,
  output logic conv_active_flag,
  output logic conv_irq,
  output logic [15:0] pin_disable
);
  typedef struct packed {
    adcl_pkg::adcl_conv_t conv;
    logic [7:0] cfg;
    logic trig;
    logic cfe;
    logic cgt;
    logic done_flag;
    logic irq_en;
    logic cont;
    logic [4:0] ch;
    logic [9:0] res;
    logic [9:0] cv;
    logic [7:0] pc1;
    logic [7:0] pc2;
    logic lock;
    logic irq;
    logic start;
    logic abort;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcl_state_t;

  adcl_state_t st;
  adcl_state_t next_st;

  // Compare condition on converted value
  function automatic logic cmp_hit(input logic [9:0] val,
                                   input logic [9:0] thr,
                                   input logic gt);
    logic [10:0] diff;
    diff = {1'b0, val} - {1'b0, thr};
    cmp_hit = gt ? ~diff[10] : diff[10];
  endfunction

  // Valid register word address
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= adcl_pkg::OFS_PIN_TWO);
  endfunction

  logic is_async;
  logic halt;
  logic wr_fire;
  logic sw_start;
  logic hw_start;
  logic hit;
  logic [9:0] conv_val;

  assign s_axi_awready = !st.aw_have && !st.bvalid;
  assign s_axi_wready = !st.w_have && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign afe_start = st.start;
  assign afe_abort = st.abort;
  assign channel_select = st.ch;
  assign converter_config = st.cfg;
  assign conv_active_flag = (st.conv == adcl_pkg::CONV_RUN);
  assign conv_irq = st.irq;
  assign pin_disable = {st.pc2, st.pc1};

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.abort = 1'b0;
    is_async = (st.cfg[adcl_pkg::CFG_CLK_LO +: 2] ==
                adcl_pkg::CLK_SRC_ASYNC);
    halt = light_stop_mode && !is_async;
    wr_fire = st.aw_have && st.w_have && !st.bvalid;
    sw_start = 1'b0;
    conv_val = (st.cfg[adcl_pkg::CFG_MODE_LO +: 2] ==
                adcl_pkg::MODE_EIGHT) ? {2'h0, afe_data[9:2]} : afe_data;
    hit = !st.cfe || cmp_hit(conv_val, st.cv, st.cgt);
    // Address and data channels taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_have = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wstb = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Register write
    if (wr_fire) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = addr_ok(st.awaddr) ? adcl_pkg::RESP_OKAY :
                      adcl_pkg::RESP_SLVERR;
      if (st.wstb) begin
        case (st.awaddr)
          adcl_pkg::OFS_CONFIG: begin
            next_st.cfg = st.wdata;
          end
          adcl_pkg::OFS_CTRL_TWO: begin
            next_st.trig = st.wdata[adcl_pkg::CT2_TRIG];
            next_st.cfe = st.wdata[adcl_pkg::CT2_CFE];
            next_st.cgt = st.wdata[adcl_pkg::CT2_CGT];
          end
          adcl_pkg::OFS_CTRL_ONE: begin
            next_st.done_flag = 1'b0;
            next_st.irq_en = st.wdata[adcl_pkg::CT1_IRQEN];
            next_st.cont = st.wdata[adcl_pkg::CT1_CONT];
            next_st.ch = st.wdata[4:0];
            sw_start = !st.trig;
          end
          adcl_pkg::OFS_CMP_HIGH: begin
            next_st.cv[9:8] = st.wdata[1:0];
          end
          adcl_pkg::OFS_CMP_LOW: begin
            next_st.cv[7:0] = st.wdata;
          end
          adcl_pkg::OFS_PIN_ONE: begin
            next_st.pc1 = st.wdata;
          end
          adcl_pkg::OFS_PIN_TWO: begin
            next_st.pc2 = st.wdata;
          end
          default: begin
            next_st.cfg = next_st.cfg;
          end
        endcase
      end
    end
    // Register read
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = addr_ok(s_axi_araddr) ? adcl_pkg::RESP_OKAY :
                      adcl_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        adcl_pkg::OFS_CONFIG: next_st.rdata = {24'h0, st.cfg};
        adcl_pkg::OFS_CTRL_TWO: begin
          next_st.rdata = {24'h0, (st.conv == adcl_pkg::CONV_RUN),
                           st.trig, st.cfe, st.cgt, 4'h0};
        end
        adcl_pkg::OFS_CTRL_ONE: begin
          next_st.rdata = {24'h0, st.done_flag, st.irq_en, st.cont, st.ch};
        end
        adcl_pkg::OFS_RES_HIGH: begin
          next_st.rdata = {30'h0, st.res[9:8]};
          next_st.lock = 1'b1;
        end
        adcl_pkg::OFS_RES_LOW: begin
          next_st.rdata = {24'h0, st.res[7:0]};
          next_st.lock = 1'b0;
        end
        adcl_pkg::OFS_CMP_HIGH: next_st.rdata = {30'h0, st.cv[9:8]};
        adcl_pkg::OFS_CMP_LOW: next_st.rdata = {24'h0, st.cv[7:0]};
        adcl_pkg::OFS_PIN_ONE: next_st.rdata = {24'h0, st.pc1};
        adcl_pkg::OFS_PIN_TWO: next_st.rdata = {24'h0, st.pc2};
        default: next_st.rdata = 32'h0;
      endcase
    end
    // Conversion completion; set wins over a clear this cycle
    hw_start = st.trig && hw_trigger;
    if (st.conv == adcl_pkg::CONV_RUN && afe_done && !halt) begin
      next_st.conv = adcl_pkg::CONV_IDLE;
      if (hit) begin
        next_st.done_flag = 1'b1;
        if (!st.lock) begin
          next_st.res = st.cfe ? (conv_val - st.cv) : conv_val;
        end
      end
      if (st.cont) begin
        next_st.conv = adcl_pkg::CONV_RUN;
        next_st.start = 1'b1;
      end
    end
    // New conversion start
    if (!halt && (sw_start ||
        (hw_start && st.conv == adcl_pkg::CONV_IDLE))) begin
      next_st.conv = adcl_pkg::CONV_RUN;
      next_st.start = 1'b1;
    end
    // Light stop abort on any clock source but async; a late done is dropped
    if (halt && st.conv == adcl_pkg::CONV_RUN) begin
      next_st.conv = adcl_pkg::CONV_IDLE;
      next_st.start = 1'b0;
      next_st.abort = 1'b1;
    end
    // Deep stop: disable and return to reset values
    if (deep_stop_mode) begin
      next_st.abort = (st.conv == adcl_pkg::CONV_RUN);
      next_st.start = 1'b0;
      next_st.conv = adcl_pkg::CONV_IDLE;
      next_st.cfg = adcl_pkg::CONFIG_RST;
      {next_st.trig, next_st.cfe, next_st.cgt} = 3'h0;
      {next_st.done_flag, next_st.irq_en, next_st.cont} = 3'h0;
      next_st.ch = adcl_pkg::CTRL_ONE_RST[4:0];
      next_st.res = adcl_pkg::RESULT_RST;
      next_st.cv = adcl_pkg::CMP_RST;
      next_st.pc1 = adcl_pkg::PIN_RST;
      next_st.pc2 = adcl_pkg::PIN_RST;
      next_st.lock = 1'b0;
    end
    next_st.irq = next_st.done_flag && next_st.irq_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic run;
  assign run = (st.conv == adcl_pkg::CONV_RUN);

  property p_abort_idle;
    ce && !deep_stop_mode && light_stop_mode && !is_async && run &&
      !afe_done |=> !run && afe_abort;
  endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("Light stop did not abort conversion");

  property p_result_keep;
    ce && light_stop_mode && !deep_stop_mode && !is_async |=>
      $stable(st.res);
  endproperty
  a_result_keep: assert property (p_result_keep)
    else $error("Result changed in light stop");

  property p_no_resume;
    ce && !run && light_stop_mode && !is_async |=> !run && !afe_start;
  endproperty
  a_no_resume: assert property (p_no_resume)
    else $error("Conversion resumed in light stop");

  property p_async_run;
    ce && run && light_stop_mode && is_async && !afe_done &&
      !deep_stop_mode |=> run [*1];
  endproperty
  a_async_run: assert property (p_async_run)
    else $error("Async conversion stopped in light stop");

  property p_hw_start;
    ce && !run && light_stop_mode && is_async && st.trig && hw_trigger &&
      !deep_stop_mode |=> run && afe_start;
  endproperty
  a_hw_start: assert property (p_hw_start)
    else $error("Hardware trigger did not start");

  property p_irq;
    ce && run && afe_done && !halt && !st.cfe && st.irq_en &&
      !deep_stop_mode |=> st.done_flag && conv_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Completion interrupt missing");

  property p_deep;
    ce && deep_stop_mode |=> !run && converter_config == 8'h00 &&
      pin_disable == 16'h0000 && !conv_irq;
  endproperty
  a_deep: assert property (p_deep)
    else $error("Deep stop did not reset block");

  property p_abort_noflag;
    ce && run && halt && !afe_done && !st.done_flag && !deep_stop_mode |=>
      !st.done_flag && !conv_active_flag;
  endproperty
  a_abort_noflag: assert property (p_abort_noflag)
    else $error("Abort set completion flag");

  property p_lock;
    ce && st.lock && run && afe_done && !deep_stop_mode |=>
      $stable(st.res);
  endproperty
  a_lock: assert property (p_lock)
    else $error("Locked result overwritten");

  c_done: cover property (run && afe_done && st.irq_en);
  c_abort: cover property (afe_abort && light_stop_mode);
  c_cont: cover property (run && afe_done && st.cont ##1 run);
  c_deep: cover property (deep_stop_mode && run);
endmodule

// [adcl_pkg.sv]
/*
  Package for the converter control block: register offsets, field
  positions, reset values, state types.
  Assumes a 32-bit AXI4-Lite master and one 125 MHz clock.
*/
// What this block does
// - Light stop without async clock aborts conversion
// - Light stop without async clock leaves result registers unchanged
// - Aborted conversion needs a fresh trigger
// - Async clock: conversion runs through light stop
// - Async light stop: hardware trigger or continuous start
// - Completion sets flag (only on a compare hit when compare is enabled), interrupt when enabled
// - Deep stop disables and resets all registers
// - Config register field layout
// - Divide, resolution and clock source encodings
// - Control two: active, trigger, compare bits
// - Control two bits 3:0 read zero
// - Control one: flag, irq enable, continuous, channel
// - Channel select routes input, single conversion
// - High byte read locks result pair
// - Compare value registers hold threshold
// - Pin control bits disable digital pins
package adcl_pkg;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
  localparam logic [7:0] OFS_RES_HIGH = 8'h0c;
  localparam logic [7:0] OFS_RES_LOW = 8'h10;
  localparam logic [7:0] OFS_CMP_HIGH = 8'h14;
  localparam logic [7:0] OFS_CMP_LOW = 8'h18;
  localparam logic [7:0] OFS_PIN_ONE = 8'h1c;
  localparam logic [7:0] OFS_PIN_TWO = 8'h20;
  // Config fields
  localparam int CFG_LOWPWR = 7;
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_CLK_LO = 0;
  localparam logic [1:0] CLK_SRC_BUS = 2'h0;
  localparam logic [1:0] CLK_SRC_ASYNC = 2'h3;
  localparam logic [1:0] DIV_BY_ONE = 2'h0;
  localparam logic [1:0] MODE_EIGHT = 2'h0;
  localparam logic [1:0] MODE_TEN = 2'h2;
  // Control two / one fields
  localparam int CT2_ACTIVE = 7;
  localparam int CT2_TRIG = 6;
  localparam int CT2_CFE = 5;
  localparam int CT2_CGT = 4;
  localparam int CT1_DONE = 7;
  localparam int CT1_IRQEN = 6;
  localparam int CT1_CONT = 5;
  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {CONV_IDLE = 1'b0, CONV_RUN = 1'b1} adcl_conv_t;
endpackage
